// file: rtl/bxe_cfg.svh
`ifndef BXE_CFG_SVH
`define BXE_CFG_SVH
// Opcode encodings (decoder input codes)
`define BXE_OP_IDLE 3'h0
`define BXE_OP_CLEAR 3'h1
`define BXE_OP_DEC 3'h2
`define BXE_OP_MOVE 3'h3
`define BXE_OP_LOADLIT 3'h4
`define BXE_OP_STORE 3'h5
`define BXE_OP_LITRET 3'h6
`define BXE_OP_IRQRET 3'h7
// Field positions and reset values
`define BXE_GIE_BIT 7
`define BXE_ZERO_BYTE 8'h00
`define BXE_PC_RESET 13'h0000
`define BXE_INTERRUPT_CONTROL_REG_RESET 8'h00
`endif

// file: rtl/bxe_pkg.sv
package bxe_pkg;
   // Instruction presented to the executor
   typedef struct packed {
      logic [2:0] op;
      logic dest;
      logic [6:0] faddr;
      logic [7:0] lit;
   } bxe_instr_t;
   // Decoded operation kinds
   typedef enum logic [2:0] {
      BXE_IDLE, BXE_CLEAR, BXE_DEC, BXE_MOVE, BXE_LOADLIT, BXE_STORE, BXE_LITRET, BXE_IRQRET
   } bxe_kind_t;
   // Pipeline state
   typedef enum logic {BXE_RUN, BXE_FLUSH} bxe_state_t;
endpackage

// file: rtl/bxe_core.sv
`timescale 1ns/1ps
`include "bxe_cfg.svh"
// Behaviour
// - Clear op writes 00h to accumulator and sets zero flag.
// - Decrement op subtracts one from file; dest 0 accumulator, 1 file; Z updated.
// - Move op copies file to accumulator (d=0) or back to file (d=1).
// - Move op updates zero flag from moved value for both destinations.
// - Load literal puts 8-bit literal in accumulator; flags unchanged.
// - Store op copies accumulator into addressed file; flags unchanged.
// - Literal return loads literal, pops stack top into program counter.
// - Literal return takes two instruction cycles for the refetch.
// - Interrupt return pops stack top into program counter and sets enable.
// - Global enable is bit 7 of interrupt control, cleared on reset.
module bxe_core
   import bxe_pkg::*;
#(
   parameter int FILE_DEPTH = 128,
   parameter int STACK_DEPTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Instruction in
   input wire bxe_instr_t instr,
   input wire logic instr_valid,
   // Return address pushed by the wider core
   input wire logic push_en,
   input wire logic [12:0] push_addr,
   // State out
   output logic [7:0] accum,
   output logic zero_flag,
   output logic [12:0] pc,
   output logic [7:0] interrupt_control_reg,
   output logic busy,
   output logic [3:0] stack_depth
);

   ////////////////////////////////////////////////////////////////////
   // Local storage
   logic [7:0] file_mem [FILE_DEPTH];
   logic [12:0] stack_mem [STACK_DEPTH];
   logic [2:0] sp_reg;
   bxe_state_t state_reg;
   logic [7:0] file_rd;
   logic [7:0] dec_val;
   logic take;
   logic [12:0] stack_top;

   // Zero test shared by the decrement and move ops; clear sets the flag directly
   function automatic logic is_zero(input logic [7:0] v);
      return v == `BXE_ZERO_BYTE;
   endfunction

   assign file_rd = file_mem[instr.faddr];
   assign dec_val = file_rd - 8'h01;
   assign take = instr_valid && (state_reg == BXE_RUN);
   // Return address currently on top of the stack
   assign stack_top = stack_mem[sp_reg - 3'h1];

   ////////////////////////////////////////////////////////////////////
   // Pipeline state: one flush cycle after literal return
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= BXE_RUN;
         busy <= 1'b0;
      end else if (take && instr.op == `BXE_OP_LITRET) begin
         state_reg <= BXE_FLUSH;
         busy <= 1'b1;
      end else begin
         state_reg <= BXE_RUN;
         busy <= 1'b0;
      end
   end

   // Accumulator
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         accum <= `BXE_ZERO_BYTE;
      end else if (take) begin
         unique case (instr.op)
            `BXE_OP_CLEAR: accum <= `BXE_ZERO_BYTE;
            `BXE_OP_DEC: if (!instr.dest) accum <= dec_val;
            `BXE_OP_MOVE: if (!instr.dest) accum <= file_rd;
            `BXE_OP_LOADLIT: accum <= instr.lit;
            `BXE_OP_LITRET: accum <= instr.lit;
            default: accum <= accum;
         endcase
      end
   end

   // Zero flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         zero_flag <= 1'b0;
      end else if (take) begin
         unique case (instr.op)
            `BXE_OP_CLEAR: zero_flag <= 1'b1;
            `BXE_OP_DEC: zero_flag <= is_zero(dec_val);
            `BXE_OP_MOVE: zero_flag <= is_zero(file_rd);
            default: zero_flag <= zero_flag;
         endcase
      end
   end

   // File memory, no reset
   always_ff @(posedge clock) begin
      if (take && instr.op == `BXE_OP_DEC && instr.dest) begin
         file_mem[instr.faddr] <= dec_val;
      end else if (take && instr.op == `BXE_OP_MOVE && instr.dest) begin
         file_mem[instr.faddr] <= file_rd;
      end else if (take && instr.op == `BXE_OP_STORE) begin
         file_mem[instr.faddr] <= accum;
      end
   end

   // Return stack: pop on returns, else push from core
   always_ff @(posedge clock) begin
      if (push_en && !(take && (instr.op == `BXE_OP_LITRET || instr.op == `BXE_OP_IRQRET))) begin
         stack_mem[sp_reg] <= push_addr;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sp_reg <= 3'h0;
         stack_depth <= 4'h0;
      end else if (take && (instr.op == `BXE_OP_LITRET || instr.op == `BXE_OP_IRQRET)) begin
         sp_reg <= sp_reg - 3'h1;
         if (stack_depth != 4'h0) stack_depth <= stack_depth - 4'h1;
      end else if (push_en) begin
         sp_reg <= sp_reg + 3'h1;
         if (stack_depth != 4'(STACK_DEPTH)) stack_depth <= stack_depth + 4'h1;
      end
   end

   // Program counter
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pc <= `BXE_PC_RESET;
      end else if (take) begin
         unique case (instr.op)
            `BXE_OP_LITRET: pc <= stack_top;
            `BXE_OP_IRQRET: pc <= stack_top;
            default: pc <= pc + 13'h0001;
         endcase
      end
   end

   // Interrupt control: global enable set by interrupt return
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         interrupt_control_reg <= `BXE_INTERRUPT_CONTROL_REG_RESET;
      end else if (take && instr.op == `BXE_OP_IRQRET) begin
         interrupt_control_reg[`BXE_GIE_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_litret;
      take && instr.op == `BXE_OP_LITRET;
   endsequence

   property p_clear;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_CLEAR |=> accum == 8'h00 && zero_flag;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_dec;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_DEC && !instr.dest |=> accum == $past(dec_val)
         && zero_flag == ($past(dec_val) == 8'h00);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement failed");

   property p_move;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_MOVE |=> zero_flag == ($past(file_rd) == 8'h00);
   endproperty
   a_move: assert property (p_move) else $error("move zero wrong");

   property p_move_w;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_MOVE && !instr.dest |=> accum == $past(file_rd);
   endproperty
   a_move_w: assert property (p_move_w) else $error("move to accum failed");

   property p_loadlit;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_LOADLIT |=> accum == $past(instr.lit) && $stable(zero_flag);
   endproperty
   a_loadlit: assert property (p_loadlit) else $error("load literal failed");

   property p_store;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_STORE |=> $stable(zero_flag) && $stable(accum);
   endproperty
   a_store: assert property (p_store) else $error("store touched flags");

   property p_litret;
      @(posedge clock) disable iff (!resetn)
      s_litret |=> busy && accum == $past(instr.lit) ##1 !busy;
   endproperty
   a_litret: assert property (p_litret) else $error("literal return timing");

   property p_irqret;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_IRQRET |=> interrupt_control_reg[7];
   endproperty
   a_irqret: assert property (p_irqret) else $error("enable not set");

   property p_idle;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_IDLE |=> pc == $past(pc) + 13'h0001 && $stable(accum)
         && $stable(zero_flag);
   endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");

   // Either return reloads pc from the stack top
   sequence s_return;
      take && (instr.op == `BXE_OP_LITRET || instr.op == `BXE_OP_IRQRET);
   endsequence

   property p_ret_pc;
      @(posedge clock) disable iff (!resetn)
      s_return |=> pc == $past(stack_top);
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return address wrong");

   // Flush cycle leaves architectural state alone
   property p_flush_hold;
      @(posedge clock) disable iff (!resetn)
      busy |=> $stable(accum) && $stable(zero_flag) && $stable(pc);
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("flush cycle changed state");

   // Store lands in the addressed file register
   property p_store_file;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_STORE |=> file_mem[$past(instr.faddr)] == $past(accum);
   endproperty
   a_store_file: assert property (p_store_file) else $error("store data wrong");

   // Decrement to file leaves accumulator alone
   property p_dec_file;
      @(posedge clock) disable iff (!resetn)
      take && instr.op == `BXE_OP_DEC && instr.dest
         |=> file_mem[$past(instr.faddr)] == $past(dec_val) && $stable(accum);
   endproperty
   a_dec_file: assert property (p_dec_file) else $error("decrement to file failed");

   // Global enable held clear while reset stays low
   property p_gie_reset;
      @(posedge clock)
      !resetn && !$past(resetn) |-> !interrupt_control_reg[`BXE_GIE_BIT];
   endproperty
   a_gie_reset: assert property (p_gie_reset) else $error("enable set in reset");

endmodule

// file: dv/bxe_core_tb_top.sv
`timescale 1ns/1ps
`include "bxe_cfg.svh"
module bxe_core_tb_top
   import bxe_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   // Stimulus and observed state
   logic clock, resetn, instr_valid, push_en, zero_flag, busy;
   bxe_instr_t instr;
   logic [12:0] push_addr, pc, exp_pc;
   logic [7:0] accum, interrupt_control_reg;
   logic [3:0] stack_depth;
   int fail_count = 0;
   int comparisons = 0;
   bxe_core i_dut (.clock(clock), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
      .push_en(push_en), .push_addr(push_addr), .accum(accum), .zero_flag(zero_flag), .pc(pc),
      .interrupt_control_reg(interrupt_control_reg), .busy(busy), .stack_depth(stack_depth));
   // Clock at 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One instruction, taken at the second edge; pc checked for ordinary ops
   task automatic exec(input logic [2:0] op, input logic d, input logic [6:0] fa,
         input logic [7:0] k);
      @(posedge clock);
      instr <= '{op: op, dest: d, faddr: fa, lit: k};
      instr_valid <= 1'b1;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      if (op != `BXE_OP_LITRET && op != `BXE_OP_IRQRET) begin
         exp_pc = exp_pc + 13'h0001;
         chk("pc", exp_pc, pc);
      end
   endtask
   task automatic push(input logic [12:0] a);
      @(posedge clock);
      push_en <= 1'b1;
      push_addr <= a;
      @(posedge clock);
      push_en <= 1'b0;
      #1;
   endtask
   task automatic acc_z(input logic [7:0] a, input logic z);
      chk("accum", 13'(a), 13'(accum));
      chk("zero_flag", 13'(z), 13'(zero_flag));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      chk("interrupt_control_reg", 13'h0000, 13'(interrupt_control_reg));
      chk("pc", 13'h0000, pc);
      acc_z(8'h00, 1'b0);
      chk("busy", 13'h0000, 13'(busy));
      $display("test reset done");
   endtask
   task automatic t_clear_load();
      exec(`BXE_OP_LOADLIT, 1'b0, 7'h00, 8'hA5);
      acc_z(8'hA5, 1'b0);
      exec(`BXE_OP_CLEAR, 1'b0, 7'h00, 8'h00);
      acc_z(8'h00, 1'b1);
      exec(`BXE_OP_LOADLIT, 1'b0, 7'h00, 8'h5A);
      acc_z(8'h5A, 1'b1);
      $display("test clear_load done");
   endtask
   task automatic t_file();
      exec(`BXE_OP_LOADLIT, 1'b0, 7'h00, 8'h01);
      exec(`BXE_OP_STORE, 1'b0, 7'h7F, 8'h00);
      acc_z(8'h01, 1'b1);
      exec(`BXE_OP_DEC, 1'b1, 7'h7F, 8'h00);
      acc_z(8'h01, 1'b1);
      exec(`BXE_OP_MOVE, 1'b0, 7'h7F, 8'h00);
      acc_z(8'h00, 1'b1);
      exec(`BXE_OP_DEC, 1'b0, 7'h7F, 8'h00);
      acc_z(8'hFF, 1'b0);
      exec(`BXE_OP_MOVE, 1'b1, 7'h7F, 8'h00);
      acc_z(8'hFF, 1'b1);
      exec(`BXE_OP_STORE, 1'b0, 7'h00, 8'h00);
      acc_z(8'hFF, 1'b1);
      exec(`BXE_OP_MOVE, 1'b1, 7'h00, 8'h00);
      acc_z(8'hFF, 1'b0);
      exec(`BXE_OP_IDLE, 1'b0, 7'h00, 8'h00);
      acc_z(8'hFF, 1'b0);
      // Write-backs must leave both file values intact
      exec(`BXE_OP_LOADLIT, 1'b0, 7'h00, 8'h00);
      acc_z(8'h00, 1'b0);
      exec(`BXE_OP_MOVE, 1'b0, 7'h7F, 8'h00);
      acc_z(8'h00, 1'b1);
      exec(`BXE_OP_MOVE, 1'b0, 7'h00, 8'h00);
      acc_z(8'hFF, 1'b0);
      $display("test file done");
   endtask
   task automatic t_litret();
      push(13'h0123);
      chk("depth", 13'h0001, 13'(stack_depth));
      @(posedge clock);
      instr <= '{op: `BXE_OP_LITRET, dest: 1'b0, faddr: 7'h00, lit: 8'h77};
      instr_valid <= 1'b1;
      @(posedge clock);
      instr <= '{op: `BXE_OP_LOADLIT, dest: 1'b0, faddr: 7'h00, lit: 8'h11};
      #1;
      chk("pc", 13'h0123, pc);
      chk("busy", 13'h0001, 13'(busy));
      chk("depth", 13'h0000, 13'(stack_depth));
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      acc_z(8'h77, 1'b0);
      chk("busy", 13'h0000, 13'(busy));
      exp_pc = 13'h0123;
      exec(`BXE_OP_IDLE, 1'b0, 7'h00, 8'h00);
      $display("test litret done");
   endtask
   task automatic t_irqret();
      push(13'h0ABC);
      exec(`BXE_OP_IRQRET, 1'b0, 7'h00, 8'h00);
      chk("pc", 13'h0ABC, pc);
      chk("interrupt_control_reg", 13'h0080, 13'(interrupt_control_reg));
      acc_z(8'h77, 1'b0);
      $display("test irqret done");
   endtask
   task automatic t_rearm();
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      #1;
      chk("interrupt_control_reg", 13'h0000, 13'(interrupt_control_reg));
      chk("pc", 13'h0000, pc);
      chk("depth", 13'h0000, 13'(stack_depth));
      acc_z(8'h00, 1'b0);
      exp_pc = 13'h0000;
      exec(`BXE_OP_IDLE, 1'b0, 7'h00, 8'h00);
      $display("test rearm done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence and hang guard
   initial begin
      resetn = 1'b0;
      instr_valid = 1'b0;
      push_en = 1'b0;
      push_addr = 13'h0000;
      instr = '0;
      exp_pc = 13'h0000;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      #1;
      t_reset();
      t_clear_load();
      t_file();
      t_litret();
      t_irqret();
      t_rearm();
      wrap_up();
   end
   initial begin
      #1000000;
      fail_count++;
      wrap_up();
   end
endmodule
